// [rtl/udtc_counter.sv]
// Up/down event counter with threshold-driven switch output
// What this block does
// - Falling pulse edges have no effect on the count.
// - Clear loads the count with the configured initial value.
// - While clear is high the switch is low and no edges are counted.
// - Counting starts from the initial value and levels span zero to 999999.
// - With set at or above clear, the switch sets at set level and resets below clear level.
// - With set below clear, the switch is high only inside the window from set to clear.
// - The threshold comparison runs once per scan period, so fast pulses may skip it.
// - Direct fast pins count up to 5 kHz, other sources only slow signals near 4 Hz.
// - Without retention a power loss clears count and switch, with retention both hold.
// - Either level may come from another block's live value instead of a constant.
// - An out-of-range external level is clamped to the nearest legal value.
module udtc_counter
  import udtc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        count_pulse_input,
  input  wire logic        direction_select,
  input  wire logic        count_clear,
  input  wire udtc_cnt_t   initial_count,
  input  wire udtc_level_s set_level,
  input  wire udtc_level_s clear_level,
  input  wire logic        retention_enable,
  input  wire logic        power_restore,
  output logic             switch_output,
  output udtc_cnt_t        count_value
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic udtc_cnt_t clamp_cnt(input logic [SRC_W-1:0] v);
    if (v > SRC_W'(CNT_MAX)) begin
      return CNT_MAX;
    end
    return v[CNT_W-1:0];
  endfunction

  function automatic udtc_cnt_t pick_level(input udtc_level_s l);
    if (l.use_ext) begin
      return clamp_cnt(l.ext_value);
    end
    return clamp_cnt(SRC_W'(l.fixed_value));
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pulse_sync_q, pulse_sync_d;
  logic [1:0] dir_sync_q, dir_sync_d;
  logic [1:0] clr_sync_q, clr_sync_d;
  logic [1:0] pwr_sync_q, pwr_sync_d;

  always_comb begin
    pulse_sync_d = {pulse_sync_q[1:0], count_pulse_input};
    dir_sync_d   = {dir_sync_q[0], direction_select};
    clr_sync_d   = {clr_sync_q[0], count_clear};
    pwr_sync_d   = {pwr_sync_q[0], power_restore};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_sync_q <= 3'h0;
      dir_sync_q   <= 2'h0;
      clr_sync_q   <= 2'h0;
      pwr_sync_q   <= 2'h0;
    end else begin
      pulse_sync_q <= pulse_sync_d;
      dir_sync_q   <= dir_sync_d;
      clr_sync_q   <= clr_sync_d;
      pwr_sync_q   <= pwr_sync_d;
    end
  end

  logic pulse_rise;
  logic dir_s;
  logic clr_s;
  logic pwr_s;

  assign pulse_rise = pulse_sync_q[1] & ~pulse_sync_q[2];
  assign dir_s      = dir_sync_q[1];
  assign clr_s      = clr_sync_q[1];
  assign pwr_s      = pwr_sync_q[1];

  // ----------------------------------------------------------------
  // Start-value load after reset, and power-loss edge detect
  // ----------------------------------------------------------------
  logic loaded_q, loaded_d;
  logic pwr_prev_q, pwr_prev_d;
  logic power_event;

  assign power_event = pwr_s & ~pwr_prev_q;

  always_comb begin
    pwr_prev_d = pwr_s;
    loaded_d   = 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_prev_q <= 1'b0;
      loaded_q   <= 1'b0;
    end else begin
      pwr_prev_q <= pwr_prev_d;
      loaded_q   <= loaded_d;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  udtc_cnt_t cnt_q, cnt_d;
  udtc_cnt_t init_clamped;

  assign init_clamped = clamp_cnt(SRC_W'(initial_count));

  always_comb begin
    cnt_d = cnt_q;
    if (!loaded_q) begin
      cnt_d = init_clamped;
    end else if (power_event && !retention_enable) begin
      cnt_d = CNT_RST;
    end else if (clr_s) begin
      cnt_d = init_clamped;
    end else if (pulse_rise) begin
      if (dir_s) begin
        if (cnt_q != CNT_RST) begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end else begin
        if (cnt_q < CNT_MAX) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= CNT_RST;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Scan timer
  // ----------------------------------------------------------------
  logic [SCAN_W-1:0] scan_q, scan_d;
  logic              scan_tick;

  assign scan_tick = (scan_q == SCAN_LAST);

  always_comb begin
    if (scan_tick) begin
      scan_d = SCAN_RST;
    end else begin
      scan_d = scan_q + SCAN_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_q <= SCAN_RST;
    end else begin
      scan_q <= scan_d;
    end
  end

  // ----------------------------------------------------------------
  // Threshold switch
  // ----------------------------------------------------------------
  udtc_cnt_t on_lvl;
  udtc_cnt_t off_lvl;
  logic      sw_q, sw_d;
  udtc_cnt_t out_cnt_q, out_cnt_d;

  assign on_lvl  = pick_level(set_level);
  assign off_lvl = pick_level(clear_level);

  always_comb begin
    sw_d      = sw_q;
    out_cnt_d = cnt_d;
    if (power_event && !retention_enable) begin
      sw_d = SW_RST;
    end else if (clr_s) begin
      sw_d = 1'b0;
    end else if (scan_tick) begin
      if (on_lvl >= off_lvl) begin
        if (cnt_q >= on_lvl) begin
          sw_d = 1'b1;
        end else if (cnt_q < off_lvl) begin
          sw_d = 1'b0;
        end
      end else begin
        sw_d = (cnt_q >= on_lvl) && (cnt_q < off_lvl);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_q      <= SW_RST;
      out_cnt_q <= CNT_RST;
    end else begin
      sw_q      <= sw_d;
      out_cnt_q <= out_cnt_d;
    end
  end

  assign switch_output = sw_q;
  assign count_value   = out_cnt_q;

endmodule // udtc_counter

// [rtl/udtc_pkg.sv]
// Package of constants and types for the up/down threshold counter
package udtc_pkg;

  localparam int unsigned CNT_W        = 20;
  localparam int unsigned SRC_W        = 32;
  localparam logic [19:0] CNT_MAX      = 20'hf423f;
  localparam logic [19:0] CNT_RST      = 20'h00000;
  localparam logic        SW_RST       = 1'b0;
  localparam int unsigned CLK_HZ       = 50000000;
  localparam int unsigned SCAN_US      = 100;
  localparam int unsigned SCAN_CYC     = (CLK_HZ / 1000000) * SCAN_US;
  localparam int unsigned SCAN_W       = 13;
  localparam logic [12:0] SCAN_LAST    = 13'(SCAN_CYC - 1);
  localparam logic [12:0] SCAN_RST     = 13'h0000;
  localparam int unsigned FAST_HZ      = 5000;
  localparam int unsigned SLOW_HZ      = 4;

  typedef logic [CNT_W-1:0] udtc_cnt_t;

  typedef struct packed {
    logic             use_ext;
    logic [SRC_W-1:0] ext_value;
    udtc_cnt_t        fixed_value;
  } udtc_level_s;

endpackage : udtc_pkg

// [tb/udtc_src.sv]
// Slow pulse source standing in for an input line
module udtc_src (
  input  logic clk,
  output logic pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pulse = 1'b0;
  task automatic fire(input int n);
    repeat (n) begin
      @(negedge clk) pulse = 1'b1;
      repeat (4) @(negedge clk);
      pulse = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask
endmodule // udtc_src

// [tb/udtc_sva.sv]
// Assertions for the up/down threshold counter
module udtc_sva
  import udtc_pkg::*;
(
  input logic      clk,
  input logic      rst,
  input logic      count_pulse_input,
  input logic      direction_select,
  input logic      count_clear,
  input udtc_cnt_t initial_count,
  input udtc_level_s set_level,
  input logic      retention_enable,
  input logic      power_restore,
  input logic      switch_output,
  input udtc_cnt_t count_value
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_max; count_value <= CNT_MAX; endproperty
  a_max: assert property (p_max) else $error("count over max");
  property p_clr; count_clear[*5] |-> !switch_output; endproperty
  a_clr: assert property (p_clr) else $error("switch high in clear");
  property p_ld;
    count_clear[*8] |-> count_value == ((initial_count > CNT_MAX) ? CNT_MAX : initial_count);
  endproperty
  a_ld: assert property (p_ld) else $error("clear load wrong");
  property p_up; (!count_clear && !power_restore && !direction_select)[*6] ##1
    $changed(count_value) |-> count_value == $past(count_value) + 20'h1; endproperty
  a_up: assert property (p_up) else $error("up step wrong");
  property p_dn; (!count_clear && !power_restore && direction_select)[*6] ##1
    $changed(count_value) |-> count_value == $past(count_value) - 20'h1; endproperty
  a_dn: assert property (p_dn) else $error("down step wrong");
  property p_hold;
    (!count_pulse_input && !count_clear && !power_restore)[*6] |-> $stable(count_value);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  property p_set; $rose(switch_output) && !set_level.use_ext |-> count_value >=
    set_level.fixed_value || $past(count_value) >= set_level.fixed_value; endproperty
  a_set: assert property (p_set) else $error("switch rose early");
  property p_pwr; $rose(power_restore) && !retention_enable |->
    ##[1:8] (count_value == 20'h0 && !switch_output); endproperty
  a_pwr: assert property (p_pwr) else $error("power loss not cleared");
  c_rise: cover property ($rose(switch_output));
  c_fall: cover property ($fell(switch_output));
  c_clr: cover property (count_clear[*8]);
endmodule // udtc_sva
bind udtc_counter udtc_sva sva_u (.*);

// [tb/up_down_threshold_counter_tb.sv]
// Self-checking bench for the up/down threshold counter
module up_down_threshold_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import udtc_pkg::*;
  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] %0t mismatch", $time); end end
  logic        clk, rst, cpi, dir, clr, ret, pwr, sw;
  udtc_cnt_t   ic, ic0, cv;
  udtc_level_s sl, cll;
  int          bad_count, comparisons, cyc, m_cnt, m_on, m_off, m_sw, n;
  udtc_counter dut_u (.clk(clk), .rst(rst), .count_pulse_input(cpi), .direction_select(dir),
    .count_clear(clr), .initial_count(ic), .set_level(sl), .clear_level(cll),
    .retention_enable(ret), .power_restore(pwr), .switch_output(sw), .count_value(cv));
  udtc_src src_u (.clk(clk), .pulse(cpi));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic summarize();
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      bad_count++;
      summarize();
    end
  end
  function automatic int clamp(input longint v);
    return (v > 999999) ? 999999 : int'(v);
  endfunction
  // Wait out a scan period, then compare with the model
  task automatic chk();
    m_on = sl.use_ext ? clamp(sl.ext_value) : clamp(sl.fixed_value);
    m_off = cll.use_ext ? clamp(cll.ext_value) : clamp(cll.fixed_value);
    repeat (5010) @(negedge clk);
    if (m_on >= m_off) m_sw = (m_cnt >= m_on) ? 1 : ((m_cnt < m_off) ? 0 : m_sw);
    else m_sw = (m_cnt >= m_on && m_cnt < m_off);
    `CHK(cv, udtc_cnt_t'(m_cnt))
    `CHK(sw, 1'(m_sw))
  endtask
  task automatic pulses(input logic d, input int k);
    dir = d;
    src_u.fire(k);
    m_cnt = d ? ((m_cnt < k) ? 0 : m_cnt - k) : ((m_cnt + k > 999999) ? 999999 : m_cnt + k);
  endtask
  // Pulses sent during clear must be dropped
  task automatic clear_to(input udtc_cnt_t v);
    ic = v;
    @(negedge clk) clr = 1'b1;
    src_u.fire(2);
    `CHK(sw, 1'b0)
    clr = 1'b0;
    m_cnt = clamp(v);
    m_sw = 0;
  endtask
  task automatic power(input logic r);
    ret = r;
    @(negedge clk) pwr = 1'b1;
    repeat (6) @(negedge clk);
    pwr = 1'b0;
    if (!r) m_cnt = 0;
    if (!r) m_sw = 0;
  endtask
  initial begin
    n = $urandom(32'hd885736d);
    {rst, clr, dir, ret, pwr} = 5'h10;
    ic = 20'(100 + $urandom % 800);
    ic0 = ic;
    sl = '{1'b0, 32'h0, CNT_MAX};
    cll = sl;
    m_cnt = clamp(ic);
    m_sw = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk();
    pulses(1'b0, 1 + $urandom % 6);
    chk();
    pulses(1'b1, 1 + $urandom % 6);
    chk();
    clear_to(CNT_MAX);
    pulses(1'b0, 2);
    chk();
    clear_to(20'h0);
    pulses(1'b1, 2);
    chk();
    clear_to(20'hfffff);
    chk();
    clear_to(ic0);
    sl.fixed_value = ic0 + 20'h3;
    cll.fixed_value = ic0 + 20'h1;
    pulses(1'b0, 3);
    chk();
    pulses(1'b1, 1);
    chk();
    pulses(1'b1, 2);
    chk();
    cll = '{1'b1, 32'hffffffff, 20'h0};
    sl.fixed_value = ic0 + 20'h2;
    pulses(1'b0, 2);
    chk();
    cll.ext_value = 32'(ic0) + 32'h3;
    pulses(1'b0, 1);
    chk();
    cll.ext_value = 32'hffffffff;
    power(1'b1);
    chk();
    power(1'b0);
    chk();
    summarize();
  end
endmodule // up_down_threshold_counter_tb
